/* acrr_pkg.sv */
// How it works
// R1: Internal reference powered only while reference config bit 4 is one; resets zero.
// R2: Reference config bits 3:2 pick positive reference; default analog supply (01).
// R3: Reference config bits 1:0 pick negative reference; default analog ground (01).
// R4: Offset word bytes at 07h, 08h, 09h, low byte first, reset zero.
// R5: Three offset bytes form one 24-bit word.
// R6: Offset word is signed two's complement.
// R7: Offset is subtracted from each raw result before gain scaling.
// R8: Gain word bytes at 0Ah, 0Bh, 0Ch, low first; reset 400000h.
// R9: Gain word is unsigned straight binary.
// R10: Result multiplied by gain word over 400000h; reset value gives unity.
// R11: Gain applies to the offset-corrected value, never raw data.
// R12: Current-source routing register at 0Dh resets to FFh, both unconnected.
// R13: Bits 7:4 route source two: inputs 0-9, 1010 common, above none.
// R14: Bits 3:0 route source one with the same encoding; default none.
// R15: Calibrated result clamps to the signed 24-bit range on overflow.
package acrr_pkg;
   localparam logic [7:0] ACRR_IDX_REF = 8'h06;
   localparam logic [7:0] ACRR_IDX_OFC0 = 8'h07;
   localparam logic [7:0] ACRR_IDX_OFC1 = 8'h08;
   localparam logic [7:0] ACRR_IDX_OFC2 = 8'h09;
   localparam logic [7:0] ACRR_IDX_GAIN0 = 8'h0A;
   localparam logic [7:0] ACRR_IDX_GAIN1 = 8'h0B;
   localparam logic [7:0] ACRR_IDX_GAIN2 = 8'h0C;
   localparam logic [7:0] ACRR_IDX_ROUTE = 8'h0D;
   localparam logic [7:0] ACRR_RST_REF = 8'h05;
   localparam logic [7:0] ACRR_RST_OFC = 8'h00;
   localparam logic [7:0] ACRR_RST_GAIN0 = 8'h00;
   localparam logic [7:0] ACRR_RST_GAIN1 = 8'h00;
   localparam logic [7:0] ACRR_RST_GAIN2 = 8'h40;
   localparam logic [7:0] ACRR_RST_ROUTE = 8'hFF;
   localparam int ACRR_REF_EN_BIT = 4;
   localparam int ACRR_POS_LSB = 2;
   localparam int ACRR_NEG_LSB = 0;
   localparam int ACRR_GAIN_SHIFT = 22;
   localparam logic [3:0] ACRR_ROUTE_COMMON = 4'hA;
   localparam logic [23:0] ACRR_UNITY = 24'h400000;
   localparam logic [23:0] ACRR_MAX_POS = 24'h7FFFFF;
   localparam logic [23:0] ACRR_MAX_NEG = 24'h800000;

   typedef struct packed {
      logic [1:0] pos_select;
      logic [1:0] neg_select;
      logic internal_ref_enable;
   } acrr_ref_t;

   typedef struct packed {
      logic [10:0] source_two_route;
      logic [10:0] source_one_route;
   } acrr_route_t;

   typedef enum logic [1:0] {
      ACRR_IDLE = 2'b00,
      ACRR_SUB = 2'b01,
      ACRR_MUL = 2'b10,
      ACRR_OUT = 2'b11
   } acrr_state_t;
endpackage

/* acrr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module acrr_regs
   import acrr_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic RAW_VALID,
   input wire logic [23:0] RAW_DATA,
   output logic CAL_VALID,
   output logic [23:0] CAL_DATA,
   output acrr_ref_t REF_CTRL,
   output acrr_route_t ROUTE_CTRL
);
   logic [7:0] ref_cfg;
   logic [7:0] ofc0, ofc1, ofc2;
   logic [7:0] gain0, gain1, gain2;
   logic [7:0] route;
   logic [7:0] rd_byte;
   logic hit;
   logic wr_en;
   logic [23:0] offset_cal_word;
   logic [23:0] gain_cal_word;
   logic [24:0] diff;
   logic [23:0] diff_sat;
   logic [23:0] raw_q;
   logic [23:0] diff_q;
   logic [23:0] mul_out;
   logic [48:0] prod2;
   logic [26:0] sc2;
   acrr_state_t state;

   assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
   assign offset_cal_word = {ofc2, ofc1, ofc0}; // [R5]
   assign gain_cal_word = {gain2, gain1, gain0}; // [R5]

   // Registers answer in the access phase of every transfer, no wait states
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
         PREADY <= 1'b0;
      else
         PREADY <= PSEL && !PENABLE;
   end

   always_comb
   begin
      hit = 1'b1;
      rd_byte = 8'h00;
      case (PADDR[9:2])
         ACRR_IDX_REF: rd_byte = ref_cfg;
         ACRR_IDX_OFC0: rd_byte = ofc0;
         ACRR_IDX_OFC1: rd_byte = ofc1;
         ACRR_IDX_OFC2: rd_byte = ofc2;
         ACRR_IDX_GAIN0: rd_byte = gain0;
         ACRR_IDX_GAIN1: rd_byte = gain1;
         ACRR_IDX_GAIN2: rd_byte = gain2;
         ACRR_IDX_ROUTE: rd_byte = route;
         default: hit = 1'b0;
      endcase
      if (PADDR[31:10] != 22'h0 || PADDR[1:0] != 2'b00)
         hit = 1'b0;
   end

   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         PRDATA <= 32'h0;
         PSLVERR <= 1'b0;
      end
      else if (PSEL && !PENABLE)
      begin
         PRDATA <= (hit && !PWRITE) ? {24'h0, rd_byte} : 32'h0;
         PSLVERR <= !hit;
      end
   end

   // Reserved bits 7:5 of reference config are stored as written
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ref_cfg <= ACRR_RST_REF; // [R1] [R2] [R3]
         ofc0 <= ACRR_RST_OFC; // [R4]
         ofc1 <= ACRR_RST_OFC; // [R4]
         ofc2 <= ACRR_RST_OFC; // [R4]
         gain0 <= ACRR_RST_GAIN0; // [R8]
         gain1 <= ACRR_RST_GAIN1; // [R8]
         gain2 <= ACRR_RST_GAIN2; // [R8]
         route <= ACRR_RST_ROUTE; // [R12]
      end
      else if (wr_en && hit)
      begin
         case (PADDR[9:2])
            ACRR_IDX_REF: ref_cfg <= PWDATA[7:0];
            ACRR_IDX_OFC0: ofc0 <= PWDATA[7:0]; // [R4]
            ACRR_IDX_OFC1: ofc1 <= PWDATA[7:0];
            ACRR_IDX_OFC2: ofc2 <= PWDATA[7:0];
            ACRR_IDX_GAIN0: gain0 <= PWDATA[7:0]; // [R8]
            ACRR_IDX_GAIN1: gain1 <= PWDATA[7:0];
            ACRR_IDX_GAIN2: gain2 <= PWDATA[7:0];
            ACRR_IDX_ROUTE: route <= PWDATA[7:0]; // [R12]
            default: ;
         endcase
      end
   end

   // Decoded one-hot routing; codes above common mean no connection
   function automatic logic [10:0] decode_route(input logic [3:0] code);
      logic [10:0] hot;
      hot = 11'h000;
      if (code <= ACRR_ROUTE_COMMON)
         hot[code] = 1'b1;
      return hot;
   endfunction

   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         REF_CTRL <= '{pos_select: 2'b01, neg_select: 2'b01, internal_ref_enable: 1'b0};
         ROUTE_CTRL <= '{source_two_route: 11'h000, source_one_route: 11'h000};
      end
      else
      begin
         REF_CTRL.internal_ref_enable <= ref_cfg[ACRR_REF_EN_BIT]; // [R1]
         REF_CTRL.pos_select <= ref_cfg[ACRR_POS_LSB +: 2]; // [R2]
         REF_CTRL.neg_select <= ref_cfg[ACRR_NEG_LSB +: 2]; // [R3]
         ROUTE_CTRL.source_two_route <= decode_route(route[7:4]); // [R13]
         ROUTE_CTRL.source_one_route <= decode_route(route[3:0]); // [R14]
      end
   end

   // Offset stage then gain stage; calibration words sampled per stage,
   // so a write during a conversion may mix old and new values
   always_comb
   begin
      diff = {raw_q[23], raw_q} - {offset_cal_word[23], offset_cal_word}; // [R6] [R7]
      if (diff[24] != diff[23])
         diff_sat = diff[24] ? ACRR_MAX_NEG : ACRR_MAX_POS; // [R15]
      else
         diff_sat = diff[23:0];
   end

   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         state <= ACRR_IDLE;
         raw_q <= 24'h0;
         diff_q <= 24'h0;
         CAL_VALID <= 1'b0;
         CAL_DATA <= 24'h0;
      end
      else
      begin
         CAL_VALID <= 1'b0;
         case (state)
            ACRR_IDLE:
            begin
               if (RAW_VALID)
               begin
                  raw_q <= RAW_DATA;
                  state <= ACRR_SUB;
               end
            end
            ACRR_SUB:
            begin
               diff_q <= diff_sat; // [R7]
               state <= ACRR_MUL;
            end
            ACRR_MUL:
            begin
               state <= ACRR_OUT;
            end
            ACRR_OUT:
            begin
               CAL_DATA <= mul_out; // [R11]
               CAL_VALID <= 1'b1;
               state <= ACRR_IDLE;
            end
            default: state <= ACRR_IDLE;
         endcase
      end
   end

   always_comb
   begin
      // Unsigned gain widened with a zero sign bit [R9]
      prod2 = $signed(diff_q) * $signed({1'b0, gain_cal_word}); // [R10] [R11]
      sc2 = prod2[48:ACRR_GAIN_SHIFT];
      if ($signed(sc2) > $signed({3'b000, ACRR_MAX_POS}))
         mul_out = ACRR_MAX_POS; // [R15]
      else if ($signed(sc2) < $signed({3'b111, ACRR_MAX_NEG}))
         mul_out = ACRR_MAX_NEG;
      else
         mul_out = sc2[23:0];
   end

   chk_unity_gain: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (state == ACRR_OUT && gain_cal_word == ACRR_UNITY) |=> CAL_DATA == $past(diff_q)) // [R10]
      else $error("unity gain changed the value");
   chk_ref_enable: assert property (@(posedge REF_CLK) disable iff (!NRST)
      ##1 REF_CTRL.internal_ref_enable == $past(ref_cfg[ACRR_REF_EN_BIT])) // [R1]
      else $error("reference enable does not follow register");
   chk_cal_pulse: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (state == ACRR_IDLE && RAW_VALID) |-> ##3 !CAL_VALID ##1 CAL_VALID) // [R7]
      else $error("calibrated result late");
   chk_route_none: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (route[3:0] > ACRR_ROUTE_COMMON) |=> ROUTE_CTRL.source_one_route == 11'h000) // [R14]
      else $error("source one routed on no-connect code");
   chk_route_two: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (route[7:4] <= ACRR_ROUTE_COMMON) |=> $onehot(ROUTE_CTRL.source_two_route)) // [R13]
      else $error("source two route not one-hot");
   chk_zero_offset: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (state == ACRR_SUB && offset_cal_word == 24'h0) |=> diff_q == $past(raw_q)) // [R6]
      else $error("zero offset altered data");
   chk_pos_sel: assert property (@(posedge REF_CLK) disable iff (!NRST)
      ##1 REF_CTRL.pos_select == $past(ref_cfg[3:2])) // [R2]
      else $error("positive reference select mismatch");
   chk_neg_sel: assert property (@(posedge REF_CLK) disable iff (!NRST)
      ##1 REF_CTRL.neg_select == $past(ref_cfg[1:0])) // [R3]
      else $error("negative reference select mismatch");
endmodule
`default_nettype wire

/* acrr_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
   import acrr_pkg::*;
;
   logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, raw_valid, cal_valid, er;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [23:0] raw_data, cal_data;
   acrr_ref_t ref_ctrl;
   acrr_route_t route_ctrl;
   int mismatches = 0;
   int cmp_count = 0;
   logic [7:0] rst_val [8] = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'hFF};
   logic [23:0] cases [6][3] = '{'{24'h000005, 24'hFFFF9C, 24'h400000},
      '{24'h7FFFFF, 24'hFFFF9C, 24'h400000}, '{24'hFFFFF9, 24'hFFFF9C, 24'h200000},
      '{24'hFFFFFD, 24'h000000, 24'h200000}, '{24'h600000, 24'h000000, 24'hFFFFFF},
      '{24'h800000, 24'h000001, 24'hFFFFFF}};

   acrr_regs i_dut (.REF_CLK(ref_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .RAW_VALID(raw_valid), .RAW_DATA(raw_data), .CAL_VALID(cal_valid),
      .CAL_DATA(cal_data), .REF_CTRL(ref_ctrl), .ROUTE_CTRL(route_ctrl));

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic time_out();
      mismatches++;
      $display("CHECK FAILED at %0t: no answer", $time);
      wrap_up();
   endtask

   // Ready and read data are sampled at the edge itself, before the slave updates them
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {22'h0, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
         time_out();
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr24(input logic [7:0] idx, input logic [23:0] v);
      apb(1'b1, idx, v[7:0]);
      apb(1'b1, idx + 8'h01, v[15:8]);
      apb(1'b1, idx + 8'h02, v[23:16]);
   endtask

   function automatic logic [23:0] model(logic [23:0] raw, logic [23:0] off, logic [23:0] gn);
      logic signed [25:0] d;
      logic signed [50:0] p;
      d = $signed({{2{raw[23]}}, raw}) - $signed({{2{off[23]}}, off});
      if (d > 26'sd8388607)
         d = 26'sd8388607;
      else if (d < -26'sd8388608)
         d = -26'sd8388608;
      p = (d * $signed({1'b0, gn})) >>> 22;
      if (p > 51'sd8388607)
         return 24'h7FFFFF;
      if (p < -51'sd8388608)
         return 24'h800000;
      return p[23:0];
   endfunction

   function automatic logic [10:0] oh(logic [3:0] c);
      return (c <= 4'hA) ? (11'h001 << c) : 11'h000;
   endfunction

   // A second request while busy carries inverted data and must leave no trace
   task automatic conv(input logic [23:0] raw, input logic [23:0] off, input logic [23:0] gn);
      int n;
      n = 0;
      @(posedge ref_clk);
      raw_valid <= 1'b1;
      raw_data <= raw;
      @(posedge ref_clk);
      raw_data <= ~raw;
      @(posedge ref_clk);
      raw_valid <= 1'b0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (cal_valid !== 1'b1 && n < 12);
      if (cal_valid !== 1'b1)
         time_out();
      chk(cal_data, model(raw, off, gn));
      repeat (6)
      begin
         @(posedge ref_clk);
         chk(cal_valid, 1'b0);
      end
   endtask

   initial
   begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      raw_valid = 1'b0;
      raw_data = 24'h0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      chk(ref_ctrl, 5'b01010);
      chk(route_ctrl, 22'h0);
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b0, 8'(i + 6), 8'h00);
         chk(rd, {24'h0, rst_val[i]});
         chk(er, 1'b0);
      end
      apb(1'b0, 8'h20, 8'h00);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, ACRR_IDX_REF, {3'b000, 1'(i), 2'(i), 2'(3 - i)});
         apb(1'b0, ACRR_IDX_REF, 8'h00);
         chk(rd, {27'h0, 1'(i), 2'(i), 2'(3 - i)});
         chk(ref_ctrl, {2'(i), 2'(3 - i), 1'(i)});
      end
      $display("test reference done");
      for (int i = 0; i < 16; i++)
      begin
         apb(1'b1, ACRR_IDX_ROUTE, {4'(i), 4'(15 - i)});
         apb(1'b0, ACRR_IDX_ROUTE, 8'h00);
         chk(rd, {24'h0, 4'(i), 4'(15 - i)});
         chk(route_ctrl, {oh(4'(i)), oh(4'(15 - i))});
      end
      $display("test routing done");
      conv(24'h123456, 24'h0, 24'h400000);
      for (int i = 0; i < 6; i++)
      begin
         wr24(ACRR_IDX_OFC0, cases[i][1]);
         wr24(ACRR_IDX_GAIN0, cases[i][2]);
         conv(cases[i][0], cases[i][1], cases[i][2]);
      end
      apb(1'b0, ACRR_IDX_OFC0, 8'h00);
      chk(rd, 32'h01);
      apb(1'b0, ACRR_IDX_GAIN2, 8'h00);
      chk(rd, 32'hFF);
      $display("test calibration done");
      wrap_up();
   end
endmodule
`default_nettype wire
